//--- hdl/pflm_pkg.sv
package pflm_pkg;

    // ====================================================
    // register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_THR = 8'h04;
    localparam logic [7:0] REG_DELAY = 8'h08;
    localparam logic [7:0] REG_START = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_PF = 8'h14;

    // ====================================================
    // field positions
    localparam int THR_LOWER_LSB = 0;
    localparam int THR_UPPER_LSB = 8;
    localparam int ST_TRIP_HI = 0;
    localparam int ST_TRIP_LO = 1;
    localparam int ST_PEND_HI = 2;
    localparam int ST_PEND_LO = 3;
    localparam int ST_OVERRIDE = 4;
    localparam int ST_MISCONFIG = 5;
    localparam int ST_CURRENT = 6;
    localparam int ST_RELAY = 7;

    // ====================================================
    // timing
    localparam int CLK_NS = 100;
    localparam int TICK_MS = 100;
    localparam int TICK_NS = TICK_MS * 1000000;
    localparam int TICK_CYCLES = TICK_NS / CLK_NS;
    localparam int RESP_DELAY_MIN_MS = 100;
    localparam int RESP_DELAY_MAX_MS = 40000;
    localparam int START_MIN_MS = 1000;
    localparam int START_MAX_MS = 100000;
    localparam logic [9:0] DELAY_MIN_TICKS = 10'(RESP_DELAY_MIN_MS / TICK_MS);
    localparam logic [9:0] DELAY_MAX_TICKS = 10'(RESP_DELAY_MAX_MS / TICK_MS);
    localparam logic [9:0] START_MIN_TICKS = 10'(START_MIN_MS / TICK_MS);
    localparam logic [9:0] START_MAX_TICKS = 10'(START_MAX_MS / TICK_MS);
    localparam logic [2:0] BLINK_TICKS = 3'h5;

    // ====================================================
    // reset values
    localparam logic [7:0] LOWER_RST = 8'h32;
    localparam logic [7:0] UPPER_RST = 8'h5a;
    localparam logic [9:0] DELAY_RST = 10'h00a;
    localparam logic [9:0] START_RST = 10'h00a;

    // ====================================================
    // function selector
    typedef enum logic [2:0] {
        func_overload = 3'b000,
        overload_with_memory = 3'b001,
        func_underload = 3'b010,
        underload_with_memory = 3'b011,
        window_function = 3'b100,
        window_with_memory = 3'b101
    } pflm_func_t;

endpackage

//--- hdl/pflm_timer.sv
`timescale 1ns/10ps
module pflm_timer (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // control
    input wire logic run_i,
    input wire logic tick_i,
    input wire logic [9:0] load_i,
    // status
    output logic expired_o
);
    import pflm_pkg::*;

    logic [9:0] count_reg;

    // ====================================================
    // down counter, reloaded while idle
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            count_reg <= 10'h000;
        end else if (!run_i) begin
            count_reg <= load_i;
        end else if (tick_i && count_reg != 10'h000) begin
            count_reg <= count_reg - 10'h001;
        end
    end

    assign expired_o = run_i && count_reg == 10'h000;

endmodule

//--- hdl/pflm_top.sv
// Behaviour
// - six functions: over, under, window, each plain or latching.
// - fault present at activation: relay energised through override, then delay runs and trips.
// - lower above upper flashes both limit lamps alternately.
// - over/window: above upper starts delay, then lamp steady, relay drops.
// - plain overload re-energises only once below lower threshold or when current stops.
// - latching overload keeps relay dropped after trip.
// - stored error clears only by reset; measuring resumes after override.
// - under/window: below lower starts delay, then lamp steady, relay drops.
// - plain underload re-energises only once above upper threshold or when current stops.
// - latching underload keeps relay dropped after trip.
// - window energises relay and lamp while healthy and untripped.
// - plain window upper trip clears once back below upper.
// - latching window keeps any trip until reset.
// - no current, nothing stored: zero lamp lit, relay energised.
// - current return restarts the starting override first.
// - limit lamps flash while delay runs, steady once expired.
// - relay lamp follows the relay.
// - supply lamp lit while powered, flashing during override.
// - response delay adjustable 0.1 s to 40 s.
// - starting override adjustable 1 s to 100 s.
`timescale 1ns/10ps
module pflm_top #(
    parameter int unsigned TICK_CYCLES = pflm_pkg::TICK_CYCLES
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // measurement front end
    input wire logic [7:0] pf_i,
    input wire logic current_flow_i,
    // relay and lamps
    output logic relay_o,
    output logic relay_state_lamp_o,
    output logic supply_lamp_o,
    output logic max_lamp_o,
    output logic min_lamp_o,
    output logic zero_current_lamp_o,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import pflm_pkg::*;

    logic [7:0] pf_meta_reg, pf_sync_reg, pf_last_reg, pf_reg;
    logic cur_meta_reg, cur_reg;
    logic [19:0] tick_cnt_reg;
    logic tick_reg;
    logic [2:0] blink_cnt_reg;
    logic blink_reg;
    pflm_func_t func_reg;
    logic [7:0] lower_reg, upper_reg;
    logic [9:0] delay_reg, start_reg;
    logic override_reg, trip_hi_reg, trip_lo_reg;
    logic aw_have_reg, w_have_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic latch, mon_hi, mon_lo, clr_hi, clr_lo;
    logic hi_viol, lo_viol, misconfig, measuring, trip_any;
    logic pend_hi, pend_lo, pend_any, dly_done, st_done;
    logic wr_do, wr_ok;
    logic [31:0] status_word, rd_word, wr_old, wr_new;
    logic rd_ok;

    // ====================================================
    // pin synchronisers
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pf_meta_reg <= 8'h00;
            pf_sync_reg <= 8'h00;
            pf_last_reg <= 8'h00;
            pf_reg <= 8'h00;
            cur_meta_reg <= 1'b0;
            cur_reg <= 1'b0;
        end else begin
            pf_meta_reg <= pf_i;
            pf_sync_reg <= pf_meta_reg;
            pf_last_reg <= pf_sync_reg;
            // word taken only once two samples agree
            if (pf_sync_reg == pf_last_reg) begin
                pf_reg <= pf_sync_reg;
            end
            cur_meta_reg <= current_flow_i;
            cur_reg <= cur_meta_reg;
        end
    end

    // ====================================================
    // 0.1 s tick and blink phase
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            tick_cnt_reg <= 20'h00000;
            tick_reg <= 1'b0;
        end else if (tick_cnt_reg == 20'(TICK_CYCLES - 1)) begin
            tick_cnt_reg <= 20'h00000;
            tick_reg <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 20'h00001;
            tick_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            blink_cnt_reg <= 3'h0;
            blink_reg <= 1'b0;
        end else if (tick_reg) begin
            if (blink_cnt_reg == BLINK_TICKS - 3'h1) begin
                blink_cnt_reg <= 3'h0;
                blink_reg <= !blink_reg;
            end else begin
                blink_cnt_reg <= blink_cnt_reg + 3'h1;
            end
        end
    end

    // ====================================================
    // function decode
    // selector decode
    always_comb begin
        latch = 1'b0;
        mon_hi = 1'b0;
        mon_lo = 1'b0;
        clr_hi = 1'b0;
        clr_lo = 1'b0;
        case (func_reg)
            func_overload: begin
                mon_hi = 1'b1;
                clr_hi = lo_viol;
            end
            overload_with_memory: begin
                mon_hi = 1'b1;
                latch = 1'b1;
            end
            func_underload: begin
                mon_lo = 1'b1;
                clr_lo = hi_viol;
            end
            underload_with_memory: begin
                mon_lo = 1'b1;
                latch = 1'b1;
            end
            window_function: begin
                mon_hi = 1'b1;
                mon_lo = 1'b1;
                clr_hi = !hi_viol;
                clr_lo = !lo_viol;
            end
            window_with_memory: begin
                mon_hi = 1'b1;
                mon_lo = 1'b1;
                latch = 1'b1;
            end
            default: begin
                mon_hi = 1'b1;
                clr_hi = lo_viol;
            end
        endcase
    end

    assign hi_viol = pf_reg > upper_reg;
    assign lo_viol = pf_reg < lower_reg;
    assign misconfig = lower_reg > upper_reg;
    assign trip_any = trip_hi_reg || trip_lo_reg;
    assign measuring = cur_reg && !override_reg;
    assign pend_hi = measuring && mon_hi && hi_viol && !trip_any;
    assign pend_lo = measuring && mon_lo && lo_viol && !trip_any;
    assign pend_any = pend_hi || pend_lo;

    // ====================================================
    // response delay and starting override timers
    // delay aborts when violation goes
    pflm_timer u_delay (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .run_i(pend_any),
        .tick_i(tick_reg),
        .load_i(delay_reg),
        .expired_o(dly_done)
    );

    pflm_timer u_start (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .run_i(override_reg && cur_reg),
        .tick_i(tick_reg),
        .load_i(start_reg),
        .expired_o(st_done)
    );

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            override_reg <= 1'b1;
        end else if (!cur_reg) begin
            override_reg <= 1'b1;
        end else if (st_done) begin
            override_reg <= 1'b0;
        end
    end

    // ====================================================
    // trip state
    // trip follows delay expiry
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            trip_hi_reg <= 1'b0;
            trip_lo_reg <= 1'b0;
        end else if (dly_done) begin
            trip_hi_reg <= pend_hi;
            trip_lo_reg <= !pend_hi;
        end else if (!latch) begin
            if (clr_hi || !cur_reg) begin
                trip_hi_reg <= 1'b0;
            end
            if (clr_lo || !cur_reg) begin
                trip_lo_reg <= 1'b0;
            end
        end
    end

    // ====================================================
    // relay and lamps
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            relay_o <= 1'b0;
            relay_state_lamp_o <= 1'b0;
            zero_current_lamp_o <= 1'b0;
            supply_lamp_o <= 1'b0;
        end else begin
            relay_o <= !trip_any;
            relay_state_lamp_o <= !trip_any;
            zero_current_lamp_o <= !cur_reg;
            supply_lamp_o <= !override_reg || blink_reg;
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            max_lamp_o <= 1'b0;
            min_lamp_o <= 1'b0;
        end else if (misconfig) begin
            max_lamp_o <= blink_reg;
            min_lamp_o <= !blink_reg;
        end else begin
            // flash while pending, steady on trip
            max_lamp_o <= trip_hi_reg || (pend_hi && blink_reg);
            min_lamp_o <= trip_lo_reg || (pend_lo && blink_reg);
        end
    end

    // ====================================================
    // axi4-lite write channel
    assign wr_do = aw_have_reg && w_have_reg && !s_axi_bvalid;
    assign wr_ok = aw_addr_reg == REG_CTRL || aw_addr_reg == REG_THR
        || aw_addr_reg == REG_DELAY || aw_addr_reg == REG_START;

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_axi_awready <= 1'b0;
            aw_have_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_have_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (wr_do) begin
            aw_have_reg <= 1'b0;
        end else if (!aw_have_reg && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_axi_wready <= 1'b0;
            w_have_reg <= 1'b0;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_have_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end else if (wr_do) begin
            w_have_reg <= 1'b0;
        end else if (!w_have_reg && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else if (wr_do) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // byte lane merge over the addressed word
    always_comb begin
        wr_old = rd_of(aw_addr_reg);
        for (int i = 0; i < 4; i++) begin
            wr_new[i*8 +: 8] = w_strb_reg[i] ? w_data_reg[i*8 +: 8]
                : wr_old[i*8 +: 8];
        end
    end

    // ====================================================
    // configuration registers
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            func_reg <= func_overload;
            lower_reg <= LOWER_RST;
            upper_reg <= UPPER_RST;
            delay_reg <= DELAY_RST;
            start_reg <= START_RST;
        end else if (wr_do) begin
            case (aw_addr_reg)
                REG_CTRL: begin
                    func_reg <= pflm_func_t'(wr_new[2:0]);
                end
                REG_THR: begin
                    lower_reg <= wr_new[THR_LOWER_LSB +: 8];
                    upper_reg <= wr_new[THR_UPPER_LSB +: 8];
                end
                REG_DELAY: begin
                    delay_reg <= clamp(wr_new[9:0], DELAY_MIN_TICKS,
                        DELAY_MAX_TICKS);
                end
                REG_START: begin
                    start_reg <= clamp(wr_new[9:0], START_MIN_TICKS,
                        START_MAX_TICKS);
                end
                default: begin
                end
            endcase
        end
    end

    function automatic logic [9:0] clamp(input logic [9:0] v,
        input logic [9:0] lo, input logic [9:0] hi);
        if (v < lo) begin
            return lo;
        end else if (v > hi) begin
            return hi;
        end
        return v;
    endfunction

    // ====================================================
    // axi4-lite read channel
    always_comb begin
        status_word = 32'h00000000;
        status_word[ST_TRIP_HI] = trip_hi_reg;
        status_word[ST_TRIP_LO] = trip_lo_reg;
        status_word[ST_PEND_HI] = pend_hi;
        status_word[ST_PEND_LO] = pend_lo;
        status_word[ST_OVERRIDE] = override_reg;
        status_word[ST_MISCONFIG] = misconfig;
        status_word[ST_CURRENT] = cur_reg;
        status_word[ST_RELAY] = relay_o;
    end

    function automatic logic [31:0] rd_of(input logic [7:0] a);
        case (a)
            REG_CTRL: return {29'h0, func_reg};
            REG_THR: return {16'h0, upper_reg, lower_reg};
            REG_DELAY: return {22'h0, delay_reg};
            REG_START: return {22'h0, start_reg};
            REG_STATUS: return status_word;
            REG_PF: return {24'h0, pf_reg};
            default: return 32'h00000000;
        endcase
    endfunction

    assign rd_word = rd_of(s_axi_araddr);
    assign rd_ok = s_axi_araddr <= REG_PF && s_axi_araddr[1:0] == 2'h0;

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // ====================================================
    // checks
    a_relay_lamp_pair: assert property (@(posedge ref_clk_i)
        disable iff (reset_i) relay_state_lamp_o == relay_o)
        else $error("relay lamp differs from relay");
    a_override_no_trip: assert property (@(posedge ref_clk_i)
        disable iff (reset_i) override_reg |=> !$rose(trip_any))
        else $error("trip during starting override");
    a_misconfig_alt: assert property (@(posedge ref_clk_i)
        disable iff (reset_i) misconfig && $stable(lower_reg)
        && $stable(upper_reg) |=> max_lamp_o != min_lamp_o)
        else $error("limit lamps not alternating");
    a_trip_relay_drop: assert property (@(posedge ref_clk_i)
        disable iff (reset_i) $rose(trip_any) |=> !relay_o [*1])
        else $error("relay not dropped after trip");
    a_latch_holds: assert property (@(posedge ref_clk_i)
        disable iff (reset_i) latch && trip_any && !dly_done |=> trip_any)
        else $error("stored trip cleared");
    a_zero_lamp_on: assert property (@(posedge ref_clk_i)
        disable iff (reset_i) !cur_reg |=> zero_current_lamp_o)
        else $error("zero current lamp dark");
    a_cur_rearm: assert property (@(posedge ref_clk_i)
        disable iff (reset_i) !cur_reg ##1 cur_reg |-> override_reg)
        else $error("override not rearmed on current return");
    a_trip_from_delay: assert property (@(posedge ref_clk_i)
        disable iff (reset_i) !dly_done |=> !$rose(trip_any))
        else $error("trip without delay expiry");
    a_over_release: assert property (@(posedge ref_clk_i)
        disable iff (reset_i) func_reg == func_overload && trip_hi_reg
        && cur_reg && !hi_viol && !lo_viol && !dly_done |=> trip_hi_reg)
        else $error("overload released above lower threshold");

endmodule

//--- tb/pflm_front_model.sv
`timescale 1ns/10ps
// ====================================================
// front end model: measurement and current sense
module pflm_front_model (
    // clock
    input wire logic ref_clk_i,
    // commanded load state
    input wire logic [7:0] pf_set_i,
    input wire logic cur_set_i,
    // pins toward the device
    output logic [7:0] pf_o = 8'h46,
    output logic current_flow_o = 1'b1
);
    // measured values settle one cycle after the load changes
    always @(posedge ref_clk_i) begin
        pf_o <= pf_set_i;
        current_flow_o <= cur_set_i;
    end
endmodule

//--- tb/pflm_top_tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module pflm_top_tb;
    import pflm_pkg::*;
    typedef struct packed {logic [2:0] fn; logic [4:0] relay;} pflm_row_t;
    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] pf_set = 8'h46;
    logic cur_set = 1'b1;
    logic [7:0] pf_i;
    logic current_flow_i;
    logic relay_o, rlamp, supply_lamp_o, max_lamp_o, min_lamp_o, zlamp;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, m0;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int num_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    // function, then relay state after each of five load steps
    pflm_row_t rows [6] = '{'{3'h0, 5'b11110}, '{3'h1, 5'b00000},
        '{3'h2, 5'b11001}, '{3'h3, 5'b00001}, '{3'h4, 5'b11100},
        '{3'h5, 5'b00000}};
    logic [7:0] pf_seq [5] = '{8'h5f, 8'h1e, 8'h46, 8'h46, 8'h5f};
    logic cur_seq [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};

    // ====================================================
    // clock, front end, device
    initial begin
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    pflm_front_model fe (.ref_clk_i(ref_clk_i), .pf_set_i(pf_set),
        .cur_set_i(cur_set), .pf_o(pf_i), .current_flow_o(current_flow_i));
    pflm_top #(.TICK_CYCLES(10)) dut (.ref_clk_i(ref_clk_i),
        .reset_i(reset_i), .pf_i(pf_i), .current_flow_i(current_flow_i),
        .relay_o(relay_o), .relay_state_lamp_o(rlamp),
        .supply_lamp_o(supply_lamp_o), .max_lamp_o(max_lamp_o),
        .min_lamp_o(min_lamp_o), .zero_current_lamp_o(zlamp),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));

    // ====================================================
    // tasks
    task automatic clk(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d,
            output logic [1:0] r);
        @(posedge ref_clk_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a, output logic [1:0] r,
            output logic [31:0] d);
        @(posedge ref_clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        r = rresp;
        d = rdata;
        rready <= 1'b0;
    endtask

    task automatic rst();
        reset_i <= 1'b1;
        clk(8);
        `CHK(relay_o, 1'b0)
        reset_i <= 1'b0;
        clk(2);
        `CHK(relay_o, 1'b1)
        `CHK(supply_lamp_o, 1'b0)
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            end_sim();
        end
    end

    // ====================================================
    // tests
    initial begin
        logic [1:0] rs;
        logic [31:0] d;
        clk(8);
        reset_i <= 1'b0;
        pf_set <= 8'h5f;
        clk(2);
        axw(REG_THR, 32'h00004060, rs);
        clk(10);
        m0 = min_lamp_o;
        `CHK(min_lamp_o ^ max_lamp_o, 1'b1)
        clk(50);
        `CHK({min_lamp_o, max_lamp_o}, {~m0, m0})
        `CHK(relay_o, 1'b1)
        axr(REG_THR, rs, d);
        `CHK(d, 32'h00004060)
        axr(REG_DELAY, rs, d);
        `CHK(d, 32'h0000000a)
        axr(REG_START, rs, d);
        `CHK(d, 32'h0000000a)
        axr(8'h18, rs, d);
        `CHK(rs, 2'h2)
        axw(REG_STATUS, 32'h0, rs);
        `CHK(rs, 2'h2)
        $display("setup and misconfig test done");
        foreach (rows[i]) begin
            rst();
            axw(REG_CTRL, {29'h0, rows[i].fn}, rs);
            axw(REG_DELAY, 32'h00000002, rs);
            pf_set <= 8'h46;
            clk(150);
            for (int s = 0; s < 5; s++) begin
                pf_set <= pf_seq[s];
                cur_set <= cur_seq[s];
                clk(80);
                `CHK({relay_o, rlamp}, {2{rows[i].relay[s]}})
                `CHK(zlamp, ~cur_seq[s])
            end
            $display("function row %0d done", i);
        end
        rst();
        axw(REG_CTRL, 32'h0, rs);
        axw(REG_DELAY, 32'h00000004, rs);
        pf_set <= 8'h46;
        clk(150);
        `CHK(supply_lamp_o, 1'b1)
        pf_set <= 8'h5f;
        clk(15);
        pf_set <= 8'h46;
        clk(80);
        `CHK({relay_o, max_lamp_o}, 2'b10)
        pf_set <= 8'h5f;
        clk(80);
        `CHK({relay_o, max_lamp_o}, 2'b01)
        clk(20);
        `CHK(max_lamp_o, 1'b1)
        $display("abort and trip test done");
        end_sim();
    end
endmodule
